// ==== hdl/link_host_ctrl.sv ====
// Notes on behaviour
// - all link traffic is ascii, hex numbers
// - host starts every legacy exchange
// - next command only after response terminator
// - node digits 00 on port1, switch on port2
// - frames: first 131, later 128 characters
// - CR ends inner frames, star CR last
// - no data word split across frames
// - next frame only after unit's CR
// - checksum is XOR, two hex digits
// - address unit by node number
// - unit may send command; right then returns
// - host reply swaps addresses, C0, 00, 02; code sends @, node digits, then the user text unchanged
// - host reply block at most 1115 characters; code sends longer ones and raises LEN_ERR_O
`timescale 1ns/1ns
`default_nettype none
module link_host_ctrl (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // command text from the user
    input wire logic [7:0] CMD_DATA_I,
    input wire logic CMD_LAST_I,
    input wire logic CMD_WORD_END_I,
    input wire logic CMD_VALID_I,
    output logic CMD_READY_O,
    input wire logic CMD_REPLY_I,
    // unit addressing
    input wire logic [1:0] PORT_SEL_I,
    input wire logic [7:0] NODE_SW_I,
    // link characters
    output logic [7:0] TX_DATA_O,
    output logic TX_VALID_O,
    input wire logic TX_READY_I,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_VALID_I,
    // received blocks and status
    output logic [7:0] RSP_DATA_O,
    output logic RSP_VALID_O,
    output logic RSP_END_O,
    output logic RSP_ERR_O,
    output logic UNIT_CMD_O,
    output logic LEN_ERR_O,
    output logic BUSY_O
);
    cmd_fifo_if #(.WIDTH(link_host_pkg::CMD_FIFO_WIDTH)) fq ();

    cmd_fifo #(
        .WIDTH(link_host_pkg::CMD_FIFO_WIDTH),
        .DEPTH(link_host_pkg::CMD_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .f(fq.store)
    );

    assign fq.in_data = {CMD_LAST_I, CMD_WORD_END_I, CMD_DATA_I};
    assign fq.in_valid = CMD_VALID_I;
    assign CMD_READY_O = fq.in_ready;

    logic [7:0] node_hi, node_lo;
    always_comb begin
        if (PORT_SEL_I == link_host_pkg::PORT_TWO) begin
            node_hi = link_host_pkg::hex_ascii(NODE_SW_I[7:4]);
            node_lo = link_host_pkg::hex_ascii(NODE_SW_I[3:0]);
        end else begin
            node_hi = link_host_pkg::CHAR_ZERO;
            node_lo = link_host_pkg::CHAR_ZERO;
        end
    end

    // receive side state
    logic [10:0] rx_cnt_reg, rx_cnt_next;
    logic [7:0] rx_xor_reg, rx_xor_next, h1_reg, h1_next, h2_reg, h2_next;
    logic star_reg, star_next, bad_reg, bad_next;
    logic hdr_o_reg, hdr_o_next, hdr_f_reg, hdr_f_next;
    logic [7:0] rsp_data_reg, rsp_data_next;
    logic rsp_valid_reg, rsp_valid_next, rsp_end_reg, rsp_end_next;
    logic rsp_err_reg, rsp_err_next, unit_cmd_reg, unit_cmd_next;
    logic ack_seen;
    logic [7:0] rx_fcs;

    always_comb begin
        rx_cnt_next = rx_cnt_reg;
        rx_xor_next = rx_xor_reg;
        h1_next = h1_reg;
        h2_next = h2_reg;
        star_next = star_reg;
        bad_next = bad_reg;
        hdr_o_next = hdr_o_reg;
        hdr_f_next = hdr_f_reg;
        rsp_data_next = rsp_data_reg;
        rsp_valid_next = 1'b0;
        rsp_end_next = 1'b0;
        rsp_err_next = 1'b0;
        unit_cmd_next = 1'b0;
        ack_seen = 1'b0;
        // the last two text characters are the checksum, so undo them
        rx_fcs = rx_xor_reg ^ h1_reg ^ h2_reg;
        if (RX_VALID_I) begin
            if (RX_DATA_I == link_host_pkg::CHAR_CR) begin
                if (star_reg) begin
                    rsp_end_next = 1'b1;
                    rsp_err_next = bad_reg || (rx_cnt_reg < 11'h005)
                        || (h2_reg != link_host_pkg::hex_ascii(rx_fcs[7:4]))
                        || (h1_reg != link_host_pkg::hex_ascii(rx_fcs[3:0]));
                    unit_cmd_next = hdr_o_reg && hdr_f_reg;
                end else if (rx_cnt_reg == '0) begin
                    ack_seen = 1'b1;
                end else begin
                    rsp_end_next = 1'b1;
                    rsp_err_next = 1'b1;
                end
                if (star_reg || rx_cnt_reg != '0) begin
                    rx_cnt_next = '0;
                    rx_xor_next = '0;
                    h1_next = '0;
                    h2_next = '0;
                    star_next = 1'b0;
                    bad_next = 1'b0;
                    hdr_o_next = 1'b0;
                    hdr_f_next = 1'b0;
                end
            end else if (RX_DATA_I == link_host_pkg::CHAR_STAR) begin
                bad_next = bad_reg || star_reg;
                star_next = 1'b1;
            end else begin
                rx_xor_next = rx_xor_reg ^ RX_DATA_I;
                h2_next = h1_reg;
                h1_next = RX_DATA_I;
                rsp_data_next = RX_DATA_I;
                rsp_valid_next = 1'b1;
                if (rx_cnt_reg != link_host_pkg::RX_CNT_MAX) begin
                    rx_cnt_next = rx_cnt_reg + 11'h001;
                end
                unique case (rx_cnt_reg)
                    11'h000: bad_next = star_reg || (RX_DATA_I != link_host_pkg::CHAR_AT);
                    11'h001: bad_next = bad_reg || (RX_DATA_I != node_hi);
                    11'h002: bad_next = bad_reg || (RX_DATA_I != node_lo);
                    11'h003: hdr_o_next = (RX_DATA_I == link_host_pkg::CHAR_O);
                    11'h004: hdr_f_next = (RX_DATA_I == link_host_pkg::CHAR_F);
                    default: bad_next = bad_reg || star_reg;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rx_cnt_reg <= '0;
            rx_xor_reg <= '0;
            h1_reg <= '0;
            h2_reg <= '0;
            star_reg <= 1'b0;
            bad_reg <= 1'b0;
            hdr_o_reg <= 1'b0;
            hdr_f_reg <= 1'b0;
            rsp_data_reg <= '0;
            rsp_valid_reg <= 1'b0;
            rsp_end_reg <= 1'b0;
            rsp_err_reg <= 1'b0;
            unit_cmd_reg <= 1'b0;
        end else begin
            rx_cnt_reg <= rx_cnt_next;
            rx_xor_reg <= rx_xor_next;
            h1_reg <= h1_next;
            h2_reg <= h2_next;
            star_reg <= star_next;
            bad_reg <= bad_next;
            hdr_o_reg <= hdr_o_next;
            hdr_f_reg <= hdr_f_next;
            rsp_data_reg <= rsp_data_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_end_reg <= rsp_end_next;
            rsp_err_reg <= rsp_err_next;
            unit_cmd_reg <= unit_cmd_next;
        end
    end

    // transmit side state
    link_host_pkg::tx_state_t st_reg, st_next;
    logic [7:0] tx_data_reg, tx_data_next, tx_xor_reg, tx_xor_next;
    logic tx_valid_reg, tx_valid_next;
    logic [7:0] fcnt_reg, fcnt_next;
    logic [10:0] blk_reg, blk_next;
    logic first_reg, first_next, term_reg, term_next, reply_reg, reply_next;
    logic len_err_reg, len_err_next;
    logic can_load, emit, add_x;
    logic [7:0] ch, limit;

    always_comb begin
        st_next = st_reg;
        tx_data_next = tx_data_reg;
        tx_xor_next = tx_xor_reg;
        fcnt_next = fcnt_reg;
        blk_next = blk_reg;
        first_next = first_reg;
        term_next = term_reg;
        reply_next = reply_reg;
        len_err_next = 1'b0;
        can_load = !tx_valid_reg || TX_READY_I;
        tx_valid_next = tx_valid_reg && !TX_READY_I;
        emit = 1'b0;
        add_x = 1'b0;
        ch = '0;
        fq.out_ready = 1'b0;
        limit = (first_reg ? link_host_pkg::FIRST_FRAME_MAX : link_host_pkg::LATER_FRAME_MAX)
            - link_host_pkg::FRAME_TAIL;
        unique case (st_reg)
            link_host_pkg::TX_IDLE: begin
                if (fq.out_valid && rx_cnt_reg == '0 && !star_reg) begin
                    reply_next = CMD_REPLY_I;
                    tx_xor_next = '0;
                    fcnt_next = link_host_pkg::FIRST_FRAME_HEAD;
                    first_next = 1'b1;
                    blk_next = '0;
                    st_next = link_host_pkg::TX_AT;
                end
            end
            link_host_pkg::TX_AT: begin
                if (can_load) begin
                    emit = 1'b1;
                    add_x = 1'b1;
                    ch = link_host_pkg::CHAR_AT;
                    st_next = link_host_pkg::TX_N1;
                end
            end
            link_host_pkg::TX_N1: begin
                if (can_load) begin
                    emit = 1'b1;
                    add_x = 1'b1;
                    ch = node_hi;
                    st_next = link_host_pkg::TX_N2;
                end
            end
            link_host_pkg::TX_N2: begin
                if (can_load) begin
                    emit = 1'b1;
                    add_x = 1'b1;
                    ch = node_lo;
                    st_next = link_host_pkg::TX_TEXT;
                end
            end
            link_host_pkg::TX_TEXT: begin
                fq.out_ready = can_load;
                if (can_load && fq.out_valid) begin
                    emit = 1'b1;
                    add_x = 1'b1;
                    ch = fq.out_data[7:0];
                    fcnt_next = fcnt_reg + 8'h01;
                    if (fq.out_data[9]) begin
                        term_next = 1'b1;
                        st_next = link_host_pkg::TX_FH;
                    end else if (fcnt_next == limit || (fq.out_data[8]
                        && fcnt_next >= limit - link_host_pkg::WORD_CHARS)) begin
                        term_next = 1'b0;
                        st_next = link_host_pkg::TX_FH;
                    end
                end
            end
            link_host_pkg::TX_FH: begin
                if (can_load) begin
                    emit = 1'b1;
                    ch = link_host_pkg::hex_ascii(tx_xor_reg[7:4]);
                    st_next = link_host_pkg::TX_FL;
                end
            end
            link_host_pkg::TX_FL: begin
                if (can_load) begin
                    emit = 1'b1;
                    ch = link_host_pkg::hex_ascii(tx_xor_reg[3:0]);
                    st_next = term_reg ? link_host_pkg::TX_STAR : link_host_pkg::TX_CR;
                end
            end
            link_host_pkg::TX_STAR: begin
                if (can_load) begin
                    emit = 1'b1;
                    ch = link_host_pkg::CHAR_STAR;
                    st_next = link_host_pkg::TX_CR;
                end
            end
            link_host_pkg::TX_CR: begin
                if (can_load) begin
                    emit = 1'b1;
                    ch = link_host_pkg::CHAR_CR;
                    len_err_next = reply_reg && term_reg
                        && (blk_reg >= link_host_pkg::REPLY_BLOCK_MAX);
                    if (!term_reg) begin
                        st_next = link_host_pkg::TX_WAIT_ACK;
                    end else if (reply_reg) begin
                        st_next = link_host_pkg::TX_IDLE;
                    end else begin
                        st_next = link_host_pkg::TX_WAIT_RSP;
                    end
                end
            end
            link_host_pkg::TX_WAIT_ACK: begin
                if (ack_seen) begin
                    tx_xor_next = '0;
                    fcnt_next = '0;
                    first_next = 1'b0;
                    st_next = link_host_pkg::TX_TEXT;
                end
            end
            link_host_pkg::TX_WAIT_RSP: begin
                if (rsp_end_next) begin
                    st_next = link_host_pkg::TX_IDLE;
                end
            end
            default: begin
                st_next = link_host_pkg::TX_IDLE;
            end
        endcase
        if (emit) begin
            tx_data_next = ch;
            tx_valid_next = 1'b1;
            if (blk_reg != link_host_pkg::RX_CNT_MAX) begin
                blk_next = blk_reg + 11'h001;
            end
        end
        if (add_x) begin
            tx_xor_next = tx_xor_reg ^ ch;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            st_reg <= link_host_pkg::TX_IDLE;
            tx_data_reg <= '0;
            tx_valid_reg <= 1'b0;
            tx_xor_reg <= '0;
            fcnt_reg <= '0;
            blk_reg <= '0;
            first_reg <= 1'b0;
            term_reg <= 1'b0;
            reply_reg <= 1'b0;
            len_err_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            tx_data_reg <= tx_data_next;
            tx_valid_reg <= tx_valid_next;
            tx_xor_reg <= tx_xor_next;
            fcnt_reg <= fcnt_next;
            blk_reg <= blk_next;
            first_reg <= first_next;
            term_reg <= term_next;
            reply_reg <= reply_next;
            len_err_reg <= len_err_next;
        end
    end

    logic busy_reg;
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (st_next != link_host_pkg::TX_IDLE);
        end
    end

    assign TX_DATA_O = tx_data_reg;
    assign TX_VALID_O = tx_valid_reg;
    assign RSP_DATA_O = rsp_data_reg;
    assign RSP_VALID_O = rsp_valid_reg;
    assign RSP_END_O = rsp_end_reg;
    assign RSP_ERR_O = rsp_err_reg;
    assign UNIT_CMD_O = unit_cmd_reg;
    assign LEN_ERR_O = len_err_reg;
    assign BUSY_O = busy_reg;
endmodule : link_host_ctrl
`default_nettype wire

// ==== hdl/link_host_pkg.sv ====
package link_host_pkg;
    // ascii characters framing a block
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [7:0] CHAR_STAR = 8'h2A;
    localparam logic [7:0] CHAR_AT = 8'h40;
    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_O = 8'h4F;
    localparam logic [7:0] CHAR_F = 8'h46;
    // frame sizes in characters, frame checksum and terminator included
    localparam logic [7:0] FIRST_FRAME_MAX = 8'h83;
    localparam logic [7:0] LATER_FRAME_MAX = 8'h80;
    localparam logic [7:0] FRAME_TAIL = 8'h04;
    localparam logic [7:0] FIRST_FRAME_HEAD = 8'h03;
    localparam logic [7:0] WORD_CHARS = 8'h04;
    localparam logic [10:0] REPLY_BLOCK_MAX = 11'h45B;
    localparam logic [10:0] RX_CNT_MAX = 11'h7FF;
    // port select codes
    localparam logic [1:0] PORT_TWO = 2'h2;
    // command buffer shape
    localparam int CMD_FIFO_WIDTH = 10;
    localparam int CMD_FIFO_DEPTH = 16;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h0,
        TX_AT = 4'h1,
        TX_N1 = 4'h2,
        TX_N2 = 4'h3,
        TX_TEXT = 4'h4,
        TX_FH = 4'h5,
        TX_FL = 4'h6,
        TX_STAR = 4'h7,
        TX_CR = 4'h8,
        TX_WAIT_ACK = 4'h9,
        TX_WAIT_RSP = 4'hA
    } tx_state_t;

    function automatic logic [7:0] hex_ascii(input logic [3:0] nib);
        hex_ascii = (nib < 4'hA) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
    endfunction : hex_ascii
endpackage : link_host_pkg

// ==== hdl/cmd_fifo_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface cmd_fifo_if #(parameter int WIDTH = 10);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;
    modport store (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
    modport user (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface : cmd_fifo_if
`default_nettype wire

// ==== hdl/cmd_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // both sides
    cmd_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = AW'(0) + (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic not_full_reg, not_full_next;
    logic out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg;
    logic push, pop, load_out;

    // read data leave through a register so the memory stays a plain array
    always_comb begin
        push = f.in_valid && not_full_reg;
        pop = out_valid_reg && f.out_ready;
        load_out = (cnt_reg != '0) && (!out_valid_reg || pop);
        wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
        rd_ptr_next = load_out ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(load_out);
        not_full_next = (cnt_next != FULL_CNT);
        out_valid_next = load_out ? 1'b1 : (pop ? 1'b0 : out_valid_reg);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            not_full_reg <= 1'b0;
            out_valid_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg <= cnt_next;
            not_full_reg <= not_full_next;
            out_valid_reg <= out_valid_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= f.in_data;
        end
        if (load_out) begin
            out_data_reg <= mem[rd_ptr_reg];
        end
    end

    assign f.in_ready = not_full_reg;
    assign f.out_valid = out_valid_reg;
    assign f.out_data = out_data_reg;
endmodule : cmd_fifo
`default_nettype wire

// ==== verification/link_host_ctrl_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module link_host_ctrl_checker (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // watched ports
    input wire logic CMD_REPLY_I,
    input wire logic [7:0] TX_DATA_O,
    input wire logic TX_VALID_O,
    input wire logic TX_READY_I,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_VALID_I,
    input wire logic [7:0] RSP_DATA_O,
    input wire logic RSP_VALID_O,
    input wire logic RSP_END_O,
    input wire logic RSP_ERR_O,
    input wire logic UNIT_CMD_O,
    input wire logic BUSY_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    logic sent, tx_cr, rx_cr, star_reg, first_reg, rsp_wait_reg, ack_wait_reg;
    logic [7:0] cnt_reg;
    assign sent = TX_VALID_O && TX_READY_I;
    assign tx_cr = sent && TX_DATA_O == link_host_pkg::CHAR_CR;
    assign rx_cr = RX_VALID_I && RX_DATA_I == link_host_pkg::CHAR_CR;
    // chars already accepted in the current frame
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            star_reg <= 1'b0;
            first_reg <= 1'b1;
            rsp_wait_reg <= 1'b0;
            ack_wait_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else begin
            if (sent) begin
                star_reg <= TX_DATA_O == link_host_pkg::CHAR_STAR;
                cnt_reg <= tx_cr ? 8'h00 : cnt_reg + 8'h01;
            end
            if (tx_cr) begin
                first_reg <= star_reg;
            end
            rsp_wait_reg <= (tx_cr && star_reg && !CMD_REPLY_I) || (rsp_wait_reg && !RSP_END_O);
            ack_wait_reg <= (tx_cr && !star_reg) || (ack_wait_reg && !rx_cr);
        end
    end
    sequence idle_leave_s;
        !BUSY_O ##1 BUSY_O;
    endsequence
    sequence at_sent_s;
        TX_VALID_O && TX_DATA_O == link_host_pkg::CHAR_AT;
    endsequence
    frame_start_a: assert property (idle_leave_s |-> ##[0:2] at_sent_s)
        else $error("block did not open with at sign");
    ascii_tx_a: assert property (TX_VALID_O |-> !TX_DATA_O[7])
        else $error("non ascii char sent");
    hold_tx_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
        else $error("char changed before accept");
    echo_rx_a: assert property (RX_VALID_I && RX_DATA_I != link_host_pkg::CHAR_CR
        && RX_DATA_I != link_host_pkg::CHAR_STAR |=> RSP_VALID_O && RSP_DATA_O == $past(RX_DATA_I))
        else $error("received char not echoed");
    end_cause_a: assert property (RSP_END_O |-> $past(rx_cr))
        else $error("block end without cr");
    err_end_a: assert property (RSP_ERR_O |-> RSP_END_O)
        else $error("error outside block end");
    unit_end_a: assert property (UNIT_CMD_O |-> RSP_END_O)
        else $error("unit command flag outside block end");
    star_cr_a: assert property (sent && TX_DATA_O == link_host_pkg::CHAR_STAR
        |=> ##[0:2] (TX_VALID_O && TX_DATA_O == link_host_pkg::CHAR_CR))
        else $error("star not followed by cr");
    rsp_wait_a: assert property (rsp_wait_reg |-> !TX_VALID_O)
        else $error("command sent before response end");
    ack_wait_a: assert property (ack_wait_reg |-> !TX_VALID_O)
        else $error("frame sent before unit delimiter");
    frame_len_a: assert property (sent |-> cnt_reg < (first_reg ?
        link_host_pkg::FIRST_FRAME_MAX : link_host_pkg::LATER_FRAME_MAX))
        else $error("frame too long");
endmodule : link_host_ctrl_checker
bind link_host_ctrl link_host_ctrl_checker chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .CMD_REPLY_I(CMD_REPLY_I), .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O),
    .TX_READY_I(TX_READY_I), .RX_DATA_I(RX_DATA_I), .RX_VALID_I(RX_VALID_I),
    .RSP_DATA_O(RSP_DATA_O), .RSP_VALID_O(RSP_VALID_O), .RSP_END_O(RSP_END_O),
    .RSP_ERR_O(RSP_ERR_O), .UNIT_CMD_O(UNIT_CMD_O), .BUSY_O(BUSY_O));
`default_nettype wire

// ==== verification/unit_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module unit_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // link side
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    // behaviour controls
    input wire logic [1:0] port_i,
    input wire logic [7:0] node_i,
    input wire logic slow_i,
    input wire logic bad_i,
    input wire logic ucmd_i,
    output var int errs_o,
    output var int frames_o
);
    logic [7:0] fq[$];
    logic [7:0] oq[$];
    logic [7:0] h1, h2;
    logic [1:0] tick = 2'h0;
    // slow mode accepts one char in four
    assign tx_ready_o = !slow_i || tick == 2'h0;
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction : hx
    function automatic logic [7:0] nd(input logic hi);
        return port_i != 2'h2 ? 8'h30 : hx(hi ? node_i[7:4] : node_i[3:0]);
    endfunction : nd
    task automatic put_block(input logic [7:0] t[$], input logic bad);
        logic [7:0] b[$];
        logic [7:0] x;
        b = {8'h40, nd(1'b1), nd(1'b0), t};
        x = bad ? 8'hFF : 8'h00;
        foreach (b[i]) x ^= b[i];
        oq = {oq, b, hx(x[7:4]), hx(x[3:0]), 8'h2A, 8'h0D};
    endtask : put_block
    task automatic check_frame();
        int n;
        int e;
        logic [7:0] x;
        logic last;
        n = fq.size();
        last = n > 0 && fq[n-1] == 8'h2A;
        e = last ? n - 3 : n - 2;
        x = 8'h00;
        for (int i = 0; i < e; i++) x ^= fq[i];
        if (e < 5 || hx(x[7:4]) !== fq[e] || hx(x[3:0]) !== fq[e+1]) errs_o++;
        if (e >= 5 && fq[0] == 8'h40) begin
            if (fq[1] !== nd(1'b1) || fq[2] !== nd(1'b0)) errs_o++;
            h1 = fq[3];
            h2 = fq[4];
        end
        frames_o++;
        fq.delete();
        // answer after terminator, ack after delimiter
        if (last) put_block({h1, h2, 8'h30, 8'h30, 8'h30, 8'h30}, bad_i);
        else oq.push_back(8'h0D);
    endtask : check_frame
    always @(posedge clk_i) begin
        tick <= tick + 2'h1;
        if (srst_i) begin
            fq.delete();
            oq.delete();
            errs_o = 0;
            frames_o = 0;
            rx_valid_o <= 1'b0;
            rx_data_o <= 8'h00;
        end else begin
            if (ucmd_i) put_block({8'h4F, 8'h46, 8'h30, 8'h38, 8'h30, 8'h30, 8'h30, 8'h30, 8'h32}, 1'b0);
            if (tx_valid_i && tx_ready_o) begin
                if (tx_data_i != 8'h0D) fq.push_back(tx_data_i);
                else check_frame();
            end
            rx_valid_o <= oq.size() > 0;
            rx_data_o <= oq.size() > 0 ? oq.pop_front() : ~rx_data_o;
        end
    end
endmodule : unit_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic srst, cmd_last, cmd_we, cmd_valid, cmd_ready, tx_valid, tx_ready, rx_valid;
    logic rsp_valid, rsp_end, rsp_err, unit_cmd, busy, slow, bad, ucmd, saw_full;
    logic last_err, last_unit, reply, len_err;
    logic [7:0] cmd_data, node_sw, tx_data, rx_data, rsp_data;
    logic [1:0] port_sel;
    int errs, frames, echo_n, end_n, cyc, failures, num_checks, len_n;
    always #4 clk = ~clk;
    link_host_ctrl DUT (.CLK_I(clk), .SRST_I(srst), .CMD_DATA_I(cmd_data),
        .CMD_LAST_I(cmd_last), .CMD_WORD_END_I(cmd_we), .CMD_VALID_I(cmd_valid),
        .CMD_READY_O(cmd_ready), .CMD_REPLY_I(reply), .PORT_SEL_I(port_sel),
        .NODE_SW_I(node_sw), .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid),
        .TX_READY_I(tx_ready), .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid),
        .RSP_DATA_O(rsp_data), .RSP_VALID_O(rsp_valid), .RSP_END_O(rsp_end),
        .RSP_ERR_O(rsp_err), .UNIT_CMD_O(unit_cmd), .LEN_ERR_O(len_err), .BUSY_O(busy));
    unit_model unit (.clk_i(clk), .srst_i(srst), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .port_i(port_sel),
        .node_i(node_sw), .slow_i(slow), .bad_i(bad), .ucmd_i(ucmd), .errs_o(errs),
        .frames_o(frames));
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask : chk_bit
    task automatic chk_num(input int got, input int exp, input string what);
        chk_bit(got == exp, 1'b1, what);
    endtask : chk_num
    // header chars, then digit text in four char words
    task automatic push_block(input logic [15:0] hdr, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            cmd_valid = 1'b1;
            cmd_data = i == 0 ? hdr[15:8] : (i == 1 ? hdr[7:0] : 8'h35);
            cmd_last = i == n - 1;
            cmd_we = i % 4 == 1 || i == n - 1;
            while (cmd_ready !== 1'b1) @(negedge clk);
        end
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : push_block
    task automatic wait_end(input int k);
        while (end_n < k) @(negedge clk);
    endtask : wait_end
    // the longest test needs under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (rsp_valid) echo_n++;
        if (len_err) len_n++;
        if (!cmd_ready) saw_full = 1'b1;
        if (rsp_end) begin
            end_n++;
            last_err = rsp_err;
            last_unit = unit_cmd;
        end
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        {srst, cmd_valid, cmd_last, cmd_we, slow, bad, ucmd, reply} = 8'h80;
        {cmd_data, node_sw, port_sel} = 18'h003A0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        chk_bit(busy, 1'b0, "busy after reset");
        chk_bit(tx_valid, 1'b0, "tx after reset");
        repeat (2) @(negedge clk);
        chk_bit(cmd_ready, 1'b1, "ready after reset");
        $display("test reset done");
        push_block(16'h5252, 2);
        push_block(16'h4D53, 2);
        wait_end(2);
        chk_num(echo_n, 22, "echo count");
        chk_bit(last_err, 1'b0, "good response flagged");
        chk_num(errs, 0, "port one frames");
        $display("test back to back done");
        port_sel = 2'h2;
        slow = 1'b1;
        saw_full = 1'b0;
        push_block(16'h5744, 300);
        wait_end(3);
        chk_num(frames, 5, "frame count");
        chk_bit(saw_full, 1'b1, "buffer never full");
        chk_num(errs, 0, "port two frames");
        chk_bit(last_err, 1'b0, "long response flagged");
        $display("test long block done");
        slow = 1'b0;
        bad = 1'b1;
        reply = 1'b1;
        push_block(16'h5252, 1120);
        wait_end(4);
        chk_bit(last_err, 1'b1, "bad check not flagged");
        chk_num(len_n, 1, "reply length not flagged");
        bad = 1'b0;
        $display("test bad check done");
        @(negedge clk);
        ucmd = 1'b1;
        @(negedge clk);
        ucmd = 1'b0;
        wait_end(5);
        chk_bit(last_unit, 1'b1, "unit command missed");
        chk_bit(last_err, 1'b0, "unit command flagged");
        $display("test unit command done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
